// *** hw/logic_stack_pkg.sv ***
/*
 * Shared constants and types for the Boolean logic stack unit and its scan sequencer.
 * Assumes a single 200 MHz clock domain and an operation source that is synchronous to it.
 */
package logic_stack_pkg;

	// ****************************************************************
	// Stack geometry
	// ****************************************************************
	// Number of one-bit levels in the evaluation stack.
	localparam int STACK_DEPTH = 9;
	// Reset value of every stack level.
	localparam logic STACK_RESET_BIT = 1'h0;

	// ****************************************************************
	// Operations and access widths
	// ****************************************************************
	// Stack operations decoded from the instruction stream.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_PUSH,
		OP_AND,
		OP_OR,
		OP_AND_POP,
		OP_OR_POP
	} stack_op_t;

	// Memory access widths; four bytes is the largest.
	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_DWORD
	} access_size_t;

	// Memory area identifiers.
	typedef enum logic [1:0] {
		AREA_INPUT,
		AREA_OUTPUT,
		AREA_MARKER
	} area_t;

	// Data path width of one access in bits.
	localparam int ACCESS_BITS = 32;
	// Byte offset width within an area.
	localparam int OFFSET_BITS = 4;
	// Bytes held by each area.
	localparam int AREA_BYTES = 16;

	// Scan phases.
	typedef enum logic [1:0] {
		PHASE_CAPTURE,
		PHASE_EVALUATE,
		PHASE_TRANSFER
	} phase_t;

endpackage

// *** hw/bit_stack.sv ***
/*
 * Nine-level, one-bit-wide Boolean evaluation stack.
 * Assumes one operation per clock, presented as a level, and a synchronous clear.
 */
`timescale 1ns/10ps
module bit_stack #(
	parameter int DEPTH = logic_stack_pkg::STACK_DEPTH
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input logic_stack_pkg::stack_op_t op,
	input wire logic operand,
	output logic [DEPTH-1:0] levels
);

	// ****************************************************************
	// Next-state selection
	// ****************************************************************
	// Each operation only looks at the top level or the top two levels.
	// only top two levels read
	wire logic top = levels[0];
	wire logic second = levels[1];
	wire logic and_top = top & operand;
	wire logic or_top = top | operand;
	wire logic and_pair = top & second;
	wire logic or_pair = top | second;
	// Push: shift down, the bottom bit falls off.
	wire logic [DEPTH-1:0] pushed = {levels[DEPTH-2:0], operand};
	// Pop after combining: shift up, fill the bottom with zero.
	wire logic [DEPTH-1:0] popped_rest = {2'h0, levels[DEPTH-1:2]};
	logic [DEPTH-1:0] next_levels;

	// Combinational selection of the new stack image.
	always_comb
	begin
		next_levels = levels;
		unique case (op)
			logic_stack_pkg::OP_NONE:
				next_levels = levels;
			logic_stack_pkg::OP_PUSH:
				next_levels = pushed;
			logic_stack_pkg::OP_AND:
				next_levels = {levels[DEPTH-1:1], and_top};
			logic_stack_pkg::OP_OR:
				next_levels = {levels[DEPTH-1:1], or_top};
			logic_stack_pkg::OP_AND_POP:
				next_levels = {popped_rest[DEPTH-2:0], and_pair};
			logic_stack_pkg::OP_OR_POP:
				next_levels = {popped_rest[DEPTH-2:0], or_pair};
			default:
				next_levels = levels;
		endcase
	end

	// ****************************************************************
	// Storage
	// ****************************************************************
	// nine one-bit levels
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			levels <= '0;
		else if (clear)
			levels <= '0;
		else
			levels <= next_levels;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	push_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && op == logic_stack_pkg::OP_PUSH) |=> levels == {$past(levels[DEPTH-2:0]), $past(operand)})
		else $error("Push did not shift the stack down.");
	and_top_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && op == logic_stack_pkg::OP_AND) |=>
		levels[0] == ($past(levels[0]) & $past(operand)) && levels[DEPTH-1:1] == $past(levels[DEPTH-1:1]))
		else $error("AND did not update only the top level.");
	or_top_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && op == logic_stack_pkg::OP_OR) |=>
		levels[0] == ($past(levels[0]) | $past(operand)) && levels[DEPTH-1:1] == $past(levels[DEPTH-1:1]))
		else $error("OR did not update only the top level.");
	pair_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && op == logic_stack_pkg::OP_OR_POP) |=>
		levels[0] == ($past(levels[0]) | $past(levels[1])) && levels[DEPTH-2:1] == $past(levels[DEPTH-1:2]))
		else $error("Combine did not pop the stack.");
	and_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clear && op == logic_stack_pkg::OP_AND_POP) |=>
		levels[0] == ($past(levels[0]) & $past(levels[1]))
		&& levels[DEPTH-2:1] == $past(levels[DEPTH-1:2]) && levels[DEPTH-1] == 1'h0)
		else $error("AND combine did not pop the stack.");
	stack_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		clear |=> levels == '0)
		else $error("Clear left a level set.");
	cover_push: cover property (@(posedge clk) disable iff (!rst_n) op == logic_stack_pkg::OP_PUSH);
	cover_pop: cover property (@(posedge clk) disable iff (!rst_n) op == logic_stack_pkg::OP_AND_POP);

endmodule

// *** hw/boolean_logic_stack_unit.sv ***
/*
 * Boolean logic stack unit with its read, evaluate and write scan sequencer.
 * Assumes an instruction source that presents one operation per cycle during evaluation
 * and raises program_end on the last one; all inputs are synchronous to clk.
 */
`timescale 1ns/10ps
module boolean_logic_stack_unit #(
	parameter int DEPTH = logic_stack_pkg::STACK_DEPTH,
	parameter int IN_BITS = 32,
	parameter int OUT_BITS = 32
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_reset,
	input wire logic [IN_BITS-1:0] input_pins,
	output logic [OUT_BITS-1:0] output_pins,
	input wire logic op_valid,
	input logic_stack_pkg::stack_op_t op,
	input wire logic op_use_memory,
	input wire logic operand_direct,
	input logic_stack_pkg::area_t operand_area,
	input wire logic [logic_stack_pkg::OFFSET_BITS-1:0] operand_offset,
	input wire logic [2:0] operand_bit,
	input wire logic store_valid,
	input logic_stack_pkg::access_size_t store_size,
	input logic_stack_pkg::area_t store_area,
	input wire logic [logic_stack_pkg::OFFSET_BITS-1:0] store_offset,
	input wire logic [logic_stack_pkg::ACCESS_BITS-1:0] store_data,
	input wire logic store_from_top,
	input wire logic program_end,
	output logic [1:0] scan_phase,
	output logic eval_active,
	output logic scan_done,
	output logic stack_level_top,
	output logic stack_level_bottom,
	output logic [DEPTH-1:0] stack_image
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	// Two-stage release so that the de-assertion is clean in this domain.
	logic rst_meta;
	logic rst_sync_n;

	// Reset synchroniser; the first stage only feeds the second.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'h0;
			rst_sync_n <= 1'h0;
		end
		else
		begin
			rst_meta <= 1'h1;
			rst_sync_n <= rst_meta;
		end
	end

	// ****************************************************************
	// Memory areas
	// ****************************************************************
	// Input image and output image are kept apart, addressed by byte offset.
	localparam int NBYTES = logic_stack_pkg::AREA_BYTES;
	logic [7:0] in_area [NBYTES];
	logic [7:0] out_area [NBYTES];
	logic [7:0] marker_area [NBYTES];

	// Bytes touched by an access of the given size; nothing wider than four.
	function automatic logic [3:0] size_lanes(input logic_stack_pkg::access_size_t size);
		unique case (size)
			logic_stack_pkg::SIZE_BYTE: size_lanes = 4'h1;
			logic_stack_pkg::SIZE_WORD: size_lanes = 4'h3;
			logic_stack_pkg::SIZE_DWORD: size_lanes = 4'hF;
			default: size_lanes = 4'h0;
		endcase
	endfunction

	// Bytes of the input image that the pins fill; wider pin sets are cut at the area size.
	localparam int CAP_BYTES = (IN_BITS / 8 < NBYTES) ? IN_BITS / 8 : NBYTES;

	// ****************************************************************
	// Scan sequencer
	// ****************************************************************
	logic_stack_pkg::phase_t phase;
	logic_stack_pkg::phase_t next_phase;
	wire logic do_reset = sync_reset;
	// Phase decodes shared by the capture, the stores and the checks.
	wire logic in_eval = phase == logic_stack_pkg::PHASE_EVALUATE;
	wire logic capture_now = phase == logic_stack_pkg::PHASE_CAPTURE;

	always_comb
	begin
		next_phase = phase;
		unique case (phase)
			logic_stack_pkg::PHASE_CAPTURE: next_phase = logic_stack_pkg::PHASE_EVALUATE;
			logic_stack_pkg::PHASE_EVALUATE:
				if (op_valid && program_end)
					next_phase = logic_stack_pkg::PHASE_TRANSFER;
			logic_stack_pkg::PHASE_TRANSFER: next_phase = logic_stack_pkg::PHASE_CAPTURE;
		endcase
	end

	// Phase register; a synchronous reset restarts the scan.
	// restart at capture
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			phase <= logic_stack_pkg::PHASE_CAPTURE;
		else if (do_reset)
			phase <= logic_stack_pkg::PHASE_CAPTURE;
		else
			phase <= next_phase;
	end

	// ****************************************************************
	// Operand fetch and stack
	// ****************************************************************
	// One byte of each area at the operand offset; the area code picks among them.
	// Reading all three in parallel costs a little logic but keeps the fetch at one level.
	wire logic [7:0] in_byte = in_area[operand_offset];
	wire logic [7:0] out_byte = out_area[operand_offset];
	wire logic [7:0] marker_byte = marker_area[operand_offset];
	// operands come from an area bit or from operand_direct
	// An unused area code reads as zero rather than as stale data.
	wire logic [7:0] fetch_byte = (operand_area == logic_stack_pkg::AREA_INPUT) ? in_byte
		: (operand_area == logic_stack_pkg::AREA_OUTPUT) ? out_byte
		: (operand_area == logic_stack_pkg::AREA_MARKER) ? marker_byte
		: 8'h00;
	wire logic mem_bit = fetch_byte[operand_bit];
	wire logic operand = op_use_memory ? mem_bit : operand_direct;
	wire logic_stack_pkg::stack_op_t gated_op = (in_eval && op_valid) ? op
		: logic_stack_pkg::OP_NONE;
	logic [DEPTH-1:0] levels;

	bit_stack #(
		.DEPTH(DEPTH)
	) u_stack (
		.clk(clk),
		.rst_n(rst_sync_n),
		.clear(do_reset),
		.op(gated_op),
		.operand(operand),
		.levels(levels)
	);

	// ****************************************************************
	// Store decode
	// ****************************************************************
	// A store writes either the given data or the top bit spread over the access.
	// widths limited to four bytes
	wire logic [3:0] lanes = size_lanes(store_size);
	wire logic [logic_stack_pkg::ACCESS_BITS-1:0] wdata = store_from_top
		? {logic_stack_pkg::ACCESS_BITS{levels[0]}} : store_data;
	wire logic store_go = in_eval && store_valid && !do_reset;

	// Image memories. Capture fills the input area; evaluation stores land in the named
	// output or marker area, and input-area stores are dropped. Input pins beyond the area size are simply not captured.
	// The images carry no reset: capture refreshes the first CAP_BYTES bytes of the input image every scan, and the
	// output image only holds what the program has stored.
	// separate areas, byte offsets
	always_ff @(posedge clk)
	begin
		// Capture copies the pins byte by byte into the input image.
		for (int b = 0; b < CAP_BYTES; b++)
		begin
			if (capture_now)
				in_area[b] <= input_pins[b*8 +: 8];
		end
		// Each store lane lands at offset plus lane; lanes past the area end are dropped.
		for (int b = 0; b < NBYTES; b++)
		begin
			for (int l = 0; l < 4; l++)
			begin
				if (store_go && lanes[l] && 32'(store_offset) + 32'(l) == 32'(b))
				begin
					if (store_area == logic_stack_pkg::AREA_OUTPUT)
						out_area[b] <= wdata[l*8 +: 8];
					else if (store_area == logic_stack_pkg::AREA_MARKER)
						marker_area[b] <= wdata[l*8 +: 8];
				end
			end
		end
	end

	// ****************************************************************
	// Output transfer and status
	// ****************************************************************
	// Only the first bytes of the output image reach the pins; the rest serve the
	// program as spare storage.
	logic [OUT_BITS-1:0] out_image;

	// Output image flattened so the transfer is one assignment.
	always_comb
	begin
		out_image = '0;
		for (int b = 0; b < OUT_BITS / 8 && b < NBYTES; b++)
			out_image[b*8 +: 8] = out_area[b];
	end

	// Outputs only move in the transfer phase, so the pins never show half a scan.
	// write outputs last
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			output_pins <= '0;
			scan_done <= 1'h0;
		end
		else
		begin
			if (phase == logic_stack_pkg::PHASE_TRANSFER)
				output_pins <= out_image;
			scan_done <= phase == logic_stack_pkg::PHASE_TRANSFER;
		end
	end

	// Registered status copies so every output leaves a flip-flop.
	always_ff @(posedge clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			scan_phase <= 2'h0;
			eval_active <= 1'h0;
			stack_level_top <= 1'h0;
			stack_level_bottom <= 1'h0;
			stack_image <= '0;
		end
		else
		begin
			// A synchronous clear sends the phase to capture whatever next_phase says.
			scan_phase <= do_reset ? logic_stack_pkg::PHASE_CAPTURE : next_phase;
			eval_active <= next_phase == logic_stack_pkg::PHASE_EVALUATE && !do_reset;
			stack_level_top <= levels[0];
			stack_level_bottom <= levels[DEPTH-1];
			stack_image <= levels;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	phase_order_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(phase == logic_stack_pkg::PHASE_CAPTURE && !do_reset) |=>
		phase == logic_stack_pkg::PHASE_EVALUATE)
		else $error("Capture was not followed by evaluation.");
	scan_loop_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(phase == logic_stack_pkg::PHASE_TRANSFER) |=> phase == logic_stack_pkg::PHASE_CAPTURE)
		else $error("Scan did not restart after transfer.");
	reset_restart_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		do_reset |=> phase == logic_stack_pkg::PHASE_CAPTURE && levels == '0)
		else $error("Reset did not restart the scan.");
	// The stack only moves while evaluating or when cleared.
	op_gate_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(!in_eval && !do_reset) |=> levels == $past(levels))
		else $error("Stack moved outside evaluation.");
	// The status flag tracks the phase that it reports.
	eval_mirror_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		eval_active == in_eval)
		else $error("Evaluate flag disagrees with the phase.");
	// Capture copies the pins into the input image.
	capture_copy_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		capture_now |=> in_area[0] == $past(input_pins[7:0]))
		else $error("Input image missed the capture.");
	// Pins only change at the end of a transfer.
	out_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(phase != logic_stack_pkg::PHASE_TRANSFER) |=> output_pins == $past(output_pins))
		else $error("Output pins moved outside transfer.");
	// A byte store lands at its offset in the output image.
	out_store_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(store_go && store_area == logic_stack_pkg::AREA_OUTPUT
		&& store_size == logic_stack_pkg::SIZE_BYTE)
		|=> out_area[$past(store_offset)] == $past(wdata[7:0]))
		else $error("Byte store missed the output image.");
	// Stores never reach the input image.
	input_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(store_go && store_area == logic_stack_pkg::AREA_INPUT)
		|=> in_area[$past(store_offset)] == $past(in_area[store_offset]))
		else $error("Store changed the input image.");
	cover_full_scan: cover property (@(posedge clk) disable iff (!rst_sync_n)
		phase == logic_stack_pkg::PHASE_EVALUATE ##1 phase == logic_stack_pkg::PHASE_TRANSFER
		##1 phase == logic_stack_pkg::PHASE_CAPTURE);
	cover_dword: cover property (@(posedge clk) disable iff (!rst_sync_n)
		store_go && store_size == logic_stack_pkg::SIZE_DWORD);
	cover_bottom: cover property (@(posedge clk) disable iff (!rst_sync_n) levels[DEPTH-1]);

endmodule

// *** test/op_sequencer.sv ***
/*
 * Behavioural instruction source: one program step per evaluate cycle.
 * Assumes the bench reloads the program while sync_reset is high.
 */
`timescale 1ns/10ps
module op_sequencer(
	input wire logic clk,
	input wire logic sync_reset,
	input wire logic eval_active,
	output logic op_valid,
	output logic_stack_pkg::stack_op_t op,
	output logic op_use_memory,
	output logic operand_direct,
	output logic_stack_pkg::area_t operand_area,
	output logic [3:0] operand_offset,
	output logic [2:0] operand_bit,
	output logic store_valid,
	output logic_stack_pkg::access_size_t store_size,
	output logic_stack_pkg::area_t store_area,
	output logic [3:0] store_offset,
	output logic [31:0] store_data,
	output logic program_end
);
	// One step: an operation or a store; the area field serves both.
	typedef struct packed {
		logic_stack_pkg::stack_op_t op;
		logic mem;
		logic nv;
		logic_stack_pkg::area_t area;
		logic [3:0] offs;
		logic [2:0] bitno;
		logic st;
		logic_stack_pkg::access_size_t size;
		logic [31:0] data;
	} step_t;
	// Program store, its length and the step now shown.
	step_t prog [16];
	int unsigned count = 0;
	int unsigned idx = 0;
	step_t cur;

	task automatic clear_prog();
		count = 0;
	endtask

	task automatic add_op(input logic_stack_pkg::stack_op_t o, input logic m, input logic v,
		input logic_stack_pkg::area_t a, input logic [3:0] f, input logic [2:0] b);
		prog[count] = '{o, m, v, a, f, b, 1'h0, logic_stack_pkg::SIZE_BYTE, 32'h0};
		count = count + 1;
	endtask

	task automatic add_store(input logic_stack_pkg::access_size_t s,
		input logic_stack_pkg::area_t a, input logic [3:0] f, input logic [31:0] d);
		prog[count] = '{logic_stack_pkg::OP_NONE, 1'h0, 1'h0, a, f, 3'h0, 1'h1, s, d};
		count = count + 1;
	endtask

	// Nothing is flagged valid outside evaluate; the fields still show the step.
	assign cur = prog[idx[3:0]];
	assign op_valid = eval_active;
	assign op = cur.op;
	assign op_use_memory = cur.mem;
	assign operand_direct = cur.nv;
	assign operand_area = cur.area;
	assign operand_offset = cur.offs;
	assign operand_bit = cur.bitno;
	assign store_valid = eval_active && cur.st;
	assign store_size = cur.size;
	assign store_area = cur.area;
	assign store_offset = cur.offs;
	assign store_data = cur.data;
	assign program_end = eval_active && (idx + 1 == count);

	// Step pointer wraps on the last step so every scan runs the same program.
	always @(posedge clk)
	begin
		if (sync_reset || program_end)
			idx <= 0;
		else if (eval_active)
			idx <= idx + 1;
	end
endmodule

// *** test/tb_top.sv ***
/*
 * Self-checking bench for the logic stack unit and its scan sequencer.
 * Assumes op_sequencer supplies the program; one 5 ns clock.
 */
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sync_reset = 1'h0;
	logic [31:0] input_pins = 32'h0;
	// Replicated-top stores are turned on by one scenario only.
	logic store_from_top = 1'h0;
	logic op_valid, op_use_memory, operand_direct, store_valid, program_end;
	logic_stack_pkg::stack_op_t op;
	logic_stack_pkg::area_t operand_area, store_area;
	logic_stack_pkg::access_size_t store_size;
	logic [3:0] operand_offset, store_offset;
	logic [2:0] operand_bit;
	logic [31:0] store_data, output_pins;
	logic [1:0] scan_phase;
	logic eval_active, scan_done, stack_level_top, stack_level_bottom;
	logic [8:0] stack_image;
	int failures = 0;
	int samples_checked = 0;
	// Reference stack, bit 0 is the top.
	logic [8:0] model;

	boolean_logic_stack_unit uut(.clk(clk), .rst_n(rst_n), .sync_reset(sync_reset),
		.input_pins(input_pins), .output_pins(output_pins), .op_valid(op_valid), .op(op),
		.op_use_memory(op_use_memory), .operand_direct(operand_direct),
		.operand_area(operand_area), .operand_offset(operand_offset),
		.operand_bit(operand_bit), .store_valid(store_valid), .store_size(store_size),
		.store_area(store_area), .store_offset(store_offset), .store_data(store_data),
		.store_from_top(store_from_top), .program_end(program_end),
		.scan_phase(scan_phase), .eval_active(eval_active), .scan_done(scan_done),
		.stack_level_top(stack_level_top), .stack_level_bottom(stack_level_bottom),
		.stack_image(stack_image));

	op_sequencer seq(.clk(clk), .sync_reset(sync_reset), .eval_active(eval_active),
		.op_valid(op_valid), .op(op), .op_use_memory(op_use_memory),
		.operand_direct(operand_direct), .operand_area(operand_area),
		.operand_offset(operand_offset), .operand_bit(operand_bit),
		.store_valid(store_valid), .store_size(store_size), .store_area(store_area),
		.store_offset(store_offset), .store_data(store_data), .program_end(program_end));

	// Free-running 200 MHz clock.
	initial
	begin
		forever #2.5 clk = ~clk;
	end

	// Reference stack update, written from the stack behaviour alone.
	function automatic logic [8:0] apply(logic [8:0] s, logic_stack_pkg::stack_op_t o, logic v);
		case (o)
			logic_stack_pkg::OP_PUSH: return {s[7:0], v};
			logic_stack_pkg::OP_AND: return {s[8:1], s[0] & v};
			logic_stack_pkg::OP_OR: return {s[8:1], s[0] | v};
			logic_stack_pkg::OP_AND_POP: return {1'h0, s[8:2], s[1] & s[0]};
			logic_stack_pkg::OP_OR_POP: return {1'h0, s[8:2], s[1] | s[0]};
			default: return s;
		endcase
	endfunction

	task automatic tally_and_finish();
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic check_stack();
		expect_eq({23'h0, stack_image}, {23'h0, model}, "stack image");
		expect_eq({31'h0, stack_level_top}, {31'h0, model[0]}, "top level");
		expect_eq({31'h0, stack_level_bottom}, {31'h0, model[8]}, "bottom level");
	endtask

	// Direct-operand step, mirrored into the reference stack.
	task automatic step(input logic_stack_pkg::stack_op_t o, input logic v);
		seq.add_op(o, 1'h0, v, logic_stack_pkg::AREA_INPUT, 4'h0, 3'h0);
		model = apply(model, o, v);
	endtask

	// Raises sync_reset and loads the program only once the clear is in force,
	// so the old scan never runs half of the new program.
	task automatic begin_prog();
		@(posedge clk);
		sync_reset <= 1'h1;
		store_from_top <= 1'h0;
		@(posedge clk);
		seq.clear_prog();
		model = 9'h000;
	endtask

	// Releases sync_reset and stops in the cycle that ends the first scan.
	task automatic run_scan();
		int n;
		@(posedge clk);
		sync_reset <= 1'h0;
		@(posedge clk);
		for (n = 0; n < 60; n++)
		begin
			@(posedge clk);
			#1;
			if (scan_done === 1'h1)
				break;
		end
		expect_eq({31'h0, n < 60}, 32'h1, "scan timeout");
	endtask

	task automatic test_push_overflow();
		logic [9:0] pat = 10'h2CD;
		begin_prog();
		for (int i = 0; i < 10; i++)
			step(logic_stack_pkg::OP_PUSH, pat[i]);
		run_scan();
		check_stack();
	endtask

	// Reload mid-run: stack clears and the scan restarts at capture.
	task automatic test_sync_clear();
		begin_prog();
		step(logic_stack_pkg::OP_NONE, 1'h0);
		@(posedge clk);
		sync_reset <= 1'h0;
		#1;
		expect_eq({31'h0, eval_active}, 32'h0, "capture first");
		@(posedge clk);
		#1;
		expect_eq({31'h0, eval_active}, 32'h1, "evaluate next");
		@(posedge clk);
		#1;
		check_stack();
	endtask

	task automatic test_logic_ops();
		logic [10:0] v = 11'h417;
		logic_stack_pkg::stack_op_t ops [11] = '{logic_stack_pkg::OP_PUSH,
			logic_stack_pkg::OP_PUSH, logic_stack_pkg::OP_PUSH, logic_stack_pkg::OP_AND,
			logic_stack_pkg::OP_OR, logic_stack_pkg::OP_OR_POP, logic_stack_pkg::OP_AND_POP,
			logic_stack_pkg::OP_PUSH, logic_stack_pkg::OP_OR, logic_stack_pkg::OP_AND,
			logic_stack_pkg::OP_OR};
		begin_prog();
		for (int i = 0; i < 11; i++)
			step(ops[i], v[i]);
		run_scan();
		check_stack();
	endtask

	// Stores of every width, an ignored input-area store, and memory operands.
	task automatic test_memory_io();
		begin_prog();
		input_pins <= 32'h0000_0800;
		seq.add_store(logic_stack_pkg::SIZE_DWORD, logic_stack_pkg::AREA_OUTPUT, 4'h0, 32'hA5C3_0F96);
		seq.add_store(logic_stack_pkg::SIZE_WORD, logic_stack_pkg::AREA_OUTPUT, 4'h2, 32'h0000_BEEF);
		seq.add_store(logic_stack_pkg::SIZE_BYTE, logic_stack_pkg::AREA_OUTPUT, 4'h0, 32'h0000_007E);
		seq.add_store(logic_stack_pkg::SIZE_BYTE, logic_stack_pkg::AREA_INPUT, 4'h1, 32'h0);
		seq.add_op(logic_stack_pkg::OP_PUSH, 1'h1, 1'h0, logic_stack_pkg::AREA_INPUT, 4'h1, 3'h3);
		seq.add_op(logic_stack_pkg::OP_PUSH, 1'h1, 1'h0, logic_stack_pkg::AREA_OUTPUT, 4'h3, 3'h7);
		seq.add_op(logic_stack_pkg::OP_AND, 1'h1, 1'h1, logic_stack_pkg::AREA_INPUT, 4'h0, 3'h0);
		model = 9'h002;
		run_scan();
		expect_eq(output_pins, 32'hBEEF_0F7E, "output pins");
		check_stack();
	endtask

	// Top-bit stores fill every lane; the marker area keeps a bit for a later operand.
	task automatic test_store_top();
		begin_prog();
		store_from_top <= 1'h1;
		step(logic_stack_pkg::OP_PUSH, 1'h1);
		seq.add_store(logic_stack_pkg::SIZE_WORD, logic_stack_pkg::AREA_OUTPUT, 4'h0, 32'h0);
		seq.add_store(logic_stack_pkg::SIZE_BYTE, logic_stack_pkg::AREA_MARKER, 4'h5, 32'h0);
		step(logic_stack_pkg::OP_PUSH, 1'h0);
		seq.add_op(logic_stack_pkg::OP_OR, 1'h1, 1'h0, logic_stack_pkg::AREA_MARKER, 4'h5, 3'h5);
		model = 9'h003;
		run_scan();
		expect_eq(output_pins, 32'hBEEF_FFFF, "top-bit store");
		check_stack();
	endtask

	// Three-step program: capture, three evaluates, transfer, repeating.
	task automatic test_scan_order();
		logic [1:0] p;
		int g;
		logic ok;
		begin_prog();
		for (int i = 0; i < 3; i++)
			step(logic_stack_pkg::OP_NONE, 1'h0);
		run_scan();
		p = scan_phase;
		for (int c = 1; c < 26; c++)
		begin
			@(posedge clk);
			#1;
			g = c % 5;
			ok = (p === 2'h0 && scan_phase === 2'h1) || (p === 2'h2 && scan_phase === 2'h0)
				|| (p === 2'h1 && (scan_phase === 2'h1 || scan_phase === 2'h2));
			expect_eq({31'h0, eval_active}, {31'h0, g >= 1 && g <= 3}, "eval cycles");
			expect_eq({31'h0, scan_done}, {31'h0, g == 0}, "scan period");
			expect_eq({31'h0, ok}, 32'h1, "phase order");
			p = scan_phase;
		end
	endtask

	// Cuts a hang short well past the expected run length.
	initial
	begin
		#(5 * 3000);
		failures++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial
	begin
		model = 9'h000;
		step(logic_stack_pkg::OP_NONE, 1'h0);
		repeat (6) @(posedge clk);
		#1;
		expect_eq(output_pins, 32'h0, "pins in reset");
		expect_eq({23'h0, stack_image}, 32'h0, "stack in reset");
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		test_push_overflow();
		test_sync_clear();
		test_logic_ops();
		test_memory_io();
		test_store_top();
		test_scan_order();
		tally_and_finish();
	end
endmodule
